// ---- core/ecs_top.sv ----
// Egress class scheduler top: APB registers, classifier, class picker.
// Assumes external class queues show a head word and pop on a pulse.
//
// Behaviour
// - One mode bit selects strict or weighted fair scheduling.
// - Strict mode always serves the highest non-empty class first.
// - Weighted mode shares grants by weighted round-robin.
// - Each class has a 0 to 15 packet quota per round.
// - A zero quota makes that class strict in weighted mode.
// - Weighted classes are served only when all strict classes are empty.
// - A strict class is served at once until empty; round then resumes.
// - Ties are broken by fixed class order, higher index first.
// - Classes 0..6 each have a quota and a mode status bit.
// - The port holds a fallback priority 0..7.
// - A table maps each priority to one class.
// - Table resets to 2,0,1,3,4,5,6,6 for priorities 0..7.
// - Class 6 is the highest precedence, class 0 the lowest.
//
// Local design decisions: the address map and the APB register port.
`default_nettype none

module ecs_top
    import ecs_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // APB clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ADDR_W-1:0]           paddr,
    input  wire logic [31:0]                 pwdata,
    output var  logic [31:0]                 prdata,
    output var  logic                        pready,
    output var  logic                        pslverr,
    // Received packet tag
    input  wire logic                        rx_valid,
    input  wire logic                        rx_tagged,
    input  wire logic [PRIO_W-1:0]           rx_priority,
    // Class queue selection for arriving packets
    output var  logic                        enq_valid,
    output var  logic [PRIO_W-1:0]           enq_priority,
    output var  logic [CLS_W-1:0]            enq_class,
    // Class queue heads
    input  wire logic [NUM_CLASS-1:0]        q_valid,
    input  wire logic [NUM_CLASS*DATA_W-1:0] q_data,
    output var  logic [NUM_CLASS-1:0]        q_pop,
    // Port transmitter
    output var  logic                        tx_valid,
    input  wire logic                        tx_ready,
    output var  logic [CLS_W-1:0]            tx_class,
    output var  logic [DATA_W-1:0]           tx_data
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // Head word must not be empty
    if (DATA_W < 1) begin : g_bad_data_w
        $error("ecs_top: DATA_W must be at least 1");
    end

    // Class and priority codes must fit their fields
    if (NUM_CLASS > (1 << CLS_W) ||
        NUM_PRIO > (1 << PRIO_W)) begin : g_bad_codes
        $error("ecs_top: class or priority field too narrow");
    end

    // Quota and map tables must fit one register word
    if (NUM_CLASS * QUOTA_W > 32 ||
        NUM_PRIO * CLS_W > 32) begin : g_bad_tables
        $error("ecs_top: table wider than a register");
    end

    // ----------------------------------------------------------------
    // Configuration and state
    // ----------------------------------------------------------------
    ecs_mode_t                      mode;
    logic [NUM_CLASS*QUOTA_W-1:0]   quota;
    logic [NUM_PRIO*CLS_W-1:0]      priority_to_class_table;
    logic [PRIO_W-1:0]              port_fallback_priority;
    logic [NUM_CLASS*QUOTA_W-1:0]   credit;
    logic [CLS_W-1:0]               last_class;
    ecs_state_t                     state;

    // Picker and bus working signals
    logic [NUM_CLASS-1:0] weighted;
    logic [NUM_CLASS-1:0] strict_set;
    logic [NUM_CLASS-1:0] sreq;
    logic [NUM_CLASS-1:0] wreq;
    logic [NUM_CLASS-1:0] creq;
    logic [CLS_W-1:0]     pick;
    logic                 reload;
    logic                 go;
    logic                 wr_en;
    logic [31:0]          rd_val;
    logic                 rd_hit;

    // Streams into and out of the output buffer
    ecs_stream_if #(.W(CLS_W + DATA_W)) buf_in ();
    ecs_stream_if #(.W(CLS_W + DATA_W)) buf_out ();

    // Highest set index wins
    function automatic logic [CLS_W-1:0] top_idx(
        input logic [NUM_CLASS-1:0] v
    );
        logic [CLS_W-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_CLASS; i++) begin
            if (v[i]) begin
                r = CLS_W'(i);
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Write lands on the completing access edge only
    assign wr_en = psel & penable & pready & pwrite;

    // Read mux for the register map
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (paddr)
            ADDR_CTRL:     rd_val[CTRL_MODE_BIT] = (mode == ECS_WRR);
            ADDR_QUOTA:    rd_val[NUM_CLASS*QUOTA_W-1:0] = quota;
            ADDR_PRIO_MAP: begin
                rd_val[NUM_PRIO*CLS_W-1:0] = priority_to_class_table;
            end
            ADDR_FALLBACK: rd_val[PRIO_W-1:0] = port_fallback_priority;
            ADDR_STATUS: begin
                rd_val[NUM_CLASS-1:0] = strict_set;
                rd_val[STAT_CLS_LSB +: CLS_W] = last_class;
                rd_val[STAT_BUSY_BIT] = |q_valid;
            end
            ADDR_CREDIT:   rd_val[NUM_CLASS*QUOTA_W-1:0] = credit;
            default:       rd_hit = 1'b0;
        endcase
    end

    // No wait state: answer prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_val : '0;
            pslverr <= psel & ~penable & ~rd_hit;
        end
    end

    // Writable configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode                    <= ECS_STRICT;
            quota                   <= QUOTA_RST;
            priority_to_class_table <= PRIO_MAP_RST;
            port_fallback_priority  <= FALLBACK_RST;
        end else if (wr_en) begin
            case (paddr)
                ADDR_CTRL: begin
                    if (pwdata[CTRL_MODE_BIT]) begin
                        mode <= ECS_WRR;
                    end else begin
                        mode <= ECS_STRICT;
                    end
                end
                ADDR_QUOTA:    quota <= pwdata[NUM_CLASS*QUOTA_W-1:0];
                ADDR_PRIO_MAP: begin
                    priority_to_class_table <= pwdata[NUM_PRIO*CLS_W-1:0];
                end
                ADDR_FALLBACK: begin
                    port_fallback_priority <= pwdata[PRIO_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Ingress classification
    // ----------------------------------------------------------------
    ecs_classify u_classify (
        .clk                     (pclk),
        .rst_n                   (presetn),
        .port_fallback_priority  (port_fallback_priority),
        .priority_to_class_table (priority_to_class_table),
        .rx_valid                (rx_valid),
        .rx_tagged               (rx_tagged),
        .rx_priority             (rx_priority),
        .enq_valid               (enq_valid),
        .enq_priority            (enq_priority),
        .enq_class               (enq_class)
    );

    // ----------------------------------------------------------------
    // Class picker
    // ----------------------------------------------------------------
    // Zero quota, or strict mode, puts a class in the strict set
    always_comb begin
        for (int i = 0; i < NUM_CLASS; i++) begin
            weighted[i] = (mode == ECS_WRR) &&
                          (quota[i*QUOTA_W +: QUOTA_W] != '0);
        end
    end

    // Requests split into strict and weighted sets
    assign strict_set = ~weighted;
    assign sreq = q_valid & strict_set;
    assign wreq = q_valid & weighted;

    // Weighted requesters that still hold round credit
    always_comb begin
        for (int i = 0; i < NUM_CLASS; i++) begin
            creq[i] = wreq[i] && (credit[i*QUOTA_W +: QUOTA_W] != '0);
        end
    end

    // Strict first, then classes with credit, else start a new round
    always_comb begin
        reload = 1'b0;
        if (|sreq) begin
            pick = top_idx(sreq);
        end else if (|creq) begin
            pick = top_idx(creq);
        end else begin
            pick   = top_idx(wreq);
            reload = 1'b1;
        end
    end

    // Grant when idle, a queue waits and the buffer has room
    assign go = (state == ST_PICK) && (|q_valid) && buf_in.ready;

    // Grant then one settle cycle so the queue can retire its head
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_PICK;
        end else begin
            case (state)
                ST_PICK:   state <= go ? ST_SETTLE : ST_PICK;
                ST_SETTLE: state <= ST_PICK;
                default:   state <= ST_PICK;
            endcase
        end
    end

    // One-hot pop pulse toward the class queues
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_pop      <= '0;
            last_class <= '0;
        end else begin
            q_pop <= '0;
            if (go) begin
                q_pop[pick] <= 1'b1;
                last_class  <= pick;
            end
        end
    end

    // Per-class round credits, spent one per weighted grant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            credit <= QUOTA_RST;
        end else if (go && weighted[pick]) begin
            if (reload) begin
                credit <= quota;
                credit[pick*QUOTA_W +: QUOTA_W] <=
                    quota[pick*QUOTA_W +: QUOTA_W] - 1'b1;
            end else begin
                credit[pick*QUOTA_W +: QUOTA_W] <=
                    credit[pick*QUOTA_W +: QUOTA_W] - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output buffer toward the transmitter
    // ----------------------------------------------------------------
    // Granted head word with its class into the buffer
    assign buf_in.valid  = go;
    assign buf_in.data   = {pick, q_data[pick*DATA_W +: DATA_W]};
    assign buf_out.ready = tx_ready;

    // Two-entry buffer absorbs transmitter stalls
    ecs_skid_buf #(.W(CLS_W + DATA_W)) u_buf (
        .clk   (pclk),
        .rst_n (presetn),
        .in_s  (buf_in),
        .out_s (buf_out)
    );

    // Transmitter side, straight from the buffer head flops
    assign tx_valid = buf_out.valid;
    assign tx_class = buf_out.data[DATA_W +: CLS_W];
    assign tx_data  = buf_out.data[DATA_W-1:0];

endmodule

`default_nettype wire

// ---- core/ecs_pkg.sv ----
// Shared constants for the egress class scheduler.
// Assumes one egress port per instance and a 32-bit APB register bus.
`default_nettype none

package ecs_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_CLASS = 7;
    localparam int NUM_PRIO  = 8;
    localparam int CLS_W     = 3;
    localparam int PRIO_W    = 3;
    localparam int QUOTA_W   = 4;
    localparam int ADDR_W    = 12;
    localparam int BUF_DEPTH = 2;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_QUOTA    = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_PRIO_MAP = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_FALLBACK = 12'h00c;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_CREDIT   = 12'h014;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_BIT = 0;
    localparam int STAT_CLS_LSB  = 8;
    localparam int STAT_BUSY_BIT = 12;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [NUM_CLASS*QUOTA_W-1:0] QUOTA_RST    = 28'h7654321;
    localparam logic [NUM_PRIO*CLS_W-1:0]    PRIO_MAP_RST = 24'hdac642;
    localparam logic [PRIO_W-1:0]            FALLBACK_RST = 3'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic {ECS_STRICT, ECS_WRR} ecs_mode_t;
    typedef enum logic [0:0] {ST_PICK, ST_SETTLE} ecs_state_t;

endpackage

`default_nettype wire

// ---- core/ecs_stream_if.sv ----
// Valid/ready stream between the scheduler core and its output buffer.
// Assumes both ends sit on the same clock.
`default_nettype none

interface ecs_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- core/ecs_skid_buf.sv ----
// Two-entry output buffer; head and spare registers, no loss on stall.
// Assumes a synchronous producer that honours in_s.ready.
`default_nettype none

module ecs_skid_buf
    import ecs_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Streams
    ecs_stream_if.snk  in_s,
    ecs_stream_if.src  out_s
);

    // Only a positive width and two entries are supported
    if (W < 1 || BUF_DEPTH != 2) begin : g_bad_cfg
        $error("ecs_skid_buf: unsupported width or depth");
    end

    logic [W-1:0] head;
    logic [W-1:0] spare;
    logic         head_v;
    logic         spare_v;
    logic         push;
    logic         pop;

    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;
    assign in_s.ready  = ~spare_v;   // Full when spare holds a word
    assign out_s.valid = head_v;
    assign out_s.data  = head;

    // Head register, refilled from spare or input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_v <= 1'b0;
            head   <= '0;
        end else if (pop) begin
            if (spare_v) begin
                head <= spare;
            end else if (push) begin
                head <= in_s.data;
            end else begin
                head_v <= 1'b0;
            end
        end else if (push && !head_v) begin
            head_v <= 1'b1;
            head   <= in_s.data;
        end
    end

    // Spare register, catches a word while head is stalled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spare_v <= 1'b0;
            spare   <= '0;
        end else if (pop && spare_v) begin
            spare_v <= 1'b0;
        end else if (push && head_v && !pop) begin
            spare_v <= 1'b1;
            spare   <= in_s.data;
        end
    end

endmodule

`default_nettype wire

// ---- core/ecs_classify.sv ----
// Ingress classification: priority fallback then priority-to-class lookup.
// Assumes receive tags arrive as one-cycle strobes on the clock.
`default_nettype none

module ecs_classify
    import ecs_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Configuration
    input  wire logic [PRIO_W-1:0]         port_fallback_priority,
    input  wire logic [NUM_PRIO*CLS_W-1:0] priority_to_class_table,
    // Received packet tag
    input  wire logic                      rx_valid,
    input  wire logic                      rx_tagged,
    input  wire logic [PRIO_W-1:0]         rx_priority,
    // Queue selection
    output var  logic                      enq_valid,
    output var  logic [PRIO_W-1:0]         enq_priority,
    output var  logic [CLS_W-1:0]          enq_class
);

    logic [PRIO_W-1:0] eff_prio;

    // Untagged packets take the port fallback
    assign eff_prio = rx_tagged ? rx_priority : port_fallback_priority;

    // Registered lookup of the egress class
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enq_valid    <= 1'b0;
            enq_priority <= '0;
            enq_class    <= '0;
        end else begin
            enq_valid    <= rx_valid;
            enq_priority <= eff_prio;
            enq_class    <= priority_to_class_table[eff_prio*CLS_W +: CLS_W];
        end
    end

endmodule

`default_nettype wire

// ---- sim/ecs_sva.sv ----
// Checker for the egress class scheduler top, bound to its ports.
// Assumes one clock pclk and the asynchronous reset presetn.
`default_nettype none

module ecs_sva
    import ecs_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB handshake
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pready,
    // Classifier
    input  wire logic                 rx_valid,
    input  wire logic                 rx_tagged,
    input  wire logic [PRIO_W-1:0]    rx_priority,
    input  wire logic                 enq_valid,
    input  wire logic [PRIO_W-1:0]    enq_priority,
    input  wire logic [CLS_W-1:0]     enq_class,
    // Queues and transmitter
    input  wire logic [NUM_CLASS-1:0] q_valid,
    input  wire logic [NUM_CLASS-1:0] q_pop,
    input  wire logic                 tx_valid,
    input  wire logic                 tx_ready,
    input  wire logic [CLS_W-1:0]     tx_class,
    input  wire logic [DATA_W-1:0]    tx_data
);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pop_onehot_a: assert property ($onehot0(q_pop))
        else $error("more than one queue popped");
    pop_valid_a: assert property (
        |q_pop |-> (q_pop & ~$past(q_valid)) == '0)
        else $error("pop of an empty queue");
    pop_space_a: assert property (|q_pop |=> q_pop == '0)
        else $error("grants closer than two cycles");
    tx_fed_a: assert property (|q_pop |-> tx_valid)
        else $error("granted word missing at transmitter");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
        && $stable(tx_class))
        else $error("stalled word changed or dropped");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    enq_match_a: assert property (enq_valid == $past(rx_valid))
        else $error("queue select not one cycle after tag");
    tagged_prio_a: assert property (
        rx_valid && rx_tagged |=> enq_priority == $past(rx_priority))
        else $error("tagged priority not kept");
    class_range_a: assert property (enq_valid |-> enq_class <= 3'h6)
        else $error("class out of range");

    // Main scenarios reached
    cover property (|q_pop);
    cover property (tx_valid && !tx_ready);
    cover property (rx_valid && !rx_tagged);
endmodule

bind ecs_top ecs_sva #(.DATA_W(DATA_W)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .rx_valid(rx_valid), .rx_tagged(rx_tagged),
    .rx_priority(rx_priority), .enq_valid(enq_valid),
    .enq_priority(enq_priority), .enq_class(enq_class),
    .q_valid(q_valid), .q_pop(q_pop), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_class(tx_class), .tx_data(tx_data)
);

`default_nettype wire

// ---- sim/ecs_queue_model.sv ----
// Seven class queues feeding the scheduler; depth counters only.
// Assumes the bench loads arrivals as one strobe, four bits per class.
`default_nettype none

module ecs_queue_model
    import ecs_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Arrivals
    input  wire logic                        load,
    input  wire logic [NUM_CLASS*4-1:0]      ld_cnt,
    // Queue heads
    input  wire logic [NUM_CLASS-1:0]        q_pop,
    output var  logic [NUM_CLASS-1:0]        q_valid,
    output var  logic [NUM_CLASS*DATA_W-1:0] q_data
);
    logic [7:0] cnt [NUM_CLASS];

    // Arrivals add, a pop retires the head
    always_ff @(posedge clk or negedge rst_n) begin
        for (int i = 0; i < NUM_CLASS; i++) begin
            if (!rst_n) begin
                cnt[i] <= 8'h0;
            end else if (load) begin
                cnt[i] <= cnt[i] + 8'(ld_cnt[4*i +: 4]);
            end else if (q_pop[i] && cnt[i] != 8'h0) begin
                cnt[i] <= cnt[i] - 8'h1;
            end
        end
    end

    // Head word: depth above class number
    always_comb begin
        for (int i = 0; i < NUM_CLASS; i++) begin
            q_valid[i] = cnt[i] != 8'h0;
            q_data[i*DATA_W +: DATA_W] = DATA_W'({cnt[i], 8'(i)});
        end
    end
endmodule

`default_nettype wire

// ---- sim/egress_class_scheduler_tb_top.sv ----
// Bench: APB register checks, classification and drain order tests.
// Assumes the queue model and the checker are compiled before it.
`default_nettype none

module egress_class_scheduler_tb_top
    import ecs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    pclk, presetn, psel, penable, pwrite;
    logic [ADDR_W-1:0]       paddr;
    logic [31:0]             pwdata, prdata, rd;
    logic                    pready, pslverr, er, load;
    logic                    rx_valid, rx_tagged, enq_valid;
    logic [PRIO_W-1:0]       rx_priority, enq_priority;
    logic [CLS_W-1:0]        enq_class, tx_class;
    logic [NUM_CLASS-1:0]    q_valid, q_pop;
    logic [NUM_CLASS*16-1:0] q_data;
    logic                    tx_valid, tx_ready;
    logic [15:0]             tx_data;
    logic [27:0]             ld_cnt;
    logic [31:0]             rv [4] = '{32'h0, 32'h7654321,
                                        32'hdac642, 32'h0};
    logic [2:0]              mx [8] = '{3'h2, 3'h0, 3'h1, 3'h3,
                                        3'h4, 3'h5, 3'h6, 3'h6};
    int                      fails = 0;
    int                      compares = 0;

    ecs_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_tagged(rx_tagged),
        .rx_priority(rx_priority), .enq_valid(enq_valid),
        .enq_priority(enq_priority), .enq_class(enq_class),
        .q_valid(q_valid), .q_data(q_data), .q_pop(q_pop),
        .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_class(tx_class), .tx_data(tx_data));

    ecs_queue_model qm (
        .clk(pclk), .rst_n(presetn), .load(load), .ld_cnt(ld_cnt),
        .q_pop(q_pop), .q_valid(q_valid), .q_data(q_data));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
        compares++;
        if (gt !== ex) begin
            fails++;
            $display("unexpected %s exp %h got %h", nm, ex, gt);
        end
    endtask

    // One APB transfer, then one idle edge
    task apb(input logic w, input logic [ADDR_W-1:0] a,
             input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'h1 && t < 20);
        if (pready !== 1'h1) begin
            chk("pready", 32'h1, 32'h0);
            summarize();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    // One packet tag in, queue selection checked a cycle later
    task cls(input logic tg, input logic [2:0] p, input logic [6:0] ex);
        rx_valid <= 1'h1;
        rx_tagged <= tg;
        rx_priority <= p;
        @(posedge pclk);
        rx_valid <= 1'h0;
        @(posedge pclk);
        chk("enq", {25'h0, ex}, {25'h0, enq_valid, enq_priority, enq_class});
    endtask

    // Load queues, drain n words under stalls, check class order
    task run(input logic [27:0] ld, input int n, input logic [31:0] sq);
        int k, t;
        logic [3:0] e;
        k = 0;
        t = 0;
        load <= 1'h1;
        ld_cnt <= ld;
        @(posedge pclk);
        load <= 1'h0;
        while (k < n && t < 400) begin
            @(posedge pclk);
            t++;
            if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
                e = sq[4*(n-1-k) +: 4];
                chk("tx", {24'h0, e, e}, {24'h0, tx_data[3:0], 1'h0, tx_class});
                k++;
            end
            tx_ready <= (t % 3 != 0);
        end
        chk("tx count", 32'(n), 32'(k));
        @(posedge pclk);
        tx_ready <= 1'h0;
    endtask

    // ----------------------------------------------------------------
    // Clock and main sequence
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = '0;
        rx_valid = 1'h0;
        rx_tagged = 1'h0;
        rx_priority = '0;
        tx_ready = 1'h0;
        load = 1'h0;
        ld_cnt = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            apb(1'h0, 12'(4*i), 32'h0);
            chk("reset value", rv[i], rd);
        end
        apb(1'h0, 12'h018, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("status strict", 32'h7f, {25'h0, rd[6:0]});
        for (int p = 0; p < 8; p++) begin
            cls(1'h1, 3'(p), {1'h1, 3'(p), mx[p]});
        end
        apb(1'h1, ADDR_FALLBACK, 32'h5);
        cls(1'h0, 3'h2, {1'h1, 3'h5, 3'h5});
        apb(1'h1, ADDR_PRIO_MAP, 32'h0);
        cls(1'h1, 3'h7, {1'h1, 3'h7, 3'h0});
        run(28'h0200202, 6, 32'h552200);
        apb(1'h1, ADDR_CTRL, 32'h1);
        run(28'h0000033, 6, 32'h110100);
        apb(1'h0, ADDR_CREDIT, 32'h0);
        chk("credit", 32'h7654320, rd);
        apb(1'h1, ADDR_QUOTA, 32'h7605321);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("status mixed", 32'h10, {25'h0, rd[6:0]});
        run(28'h0220000, 4, 32'h4455);
        summarize();
    end
endmodule

`default_nettype wire
